//--- lic_pkg.sv
// Purpose: shared constants for the line interface parameter bank
// Assumes: 32-bit AHB-Lite data, one 16-bit parameter per aligned word
// Notes:   byte address of a parameter is four times its index
package lic_pkg;

  // widths and counts
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned IDX_W     = 6;
  localparam int unsigned COEF_W    = 13;
  localparam int unsigned NUM_PARAM = 16;
  localparam int unsigned NUM_PAIR  = 3;

  // parameter indices, byte address is index * 4
  localparam logic [5:0] IDX_LC_HIGH     = 6'h1c;
  localparam logic [5:0] IDX_RING_TRIP   = 6'h1d;
  localparam logic [5:0] IDX_CM_MIN      = 6'h1e;
  localparam logic [5:0] IDX_CM_MAX      = 6'h1f;
  localparam logic [5:0] IDX_PWR_A       = 6'h20;
  localparam logic [5:0] IDX_PWR_B       = 6'h21;
  localparam logic [5:0] IDX_PWR_C       = 6'h22;
  localparam logic [5:0] IDX_LC_COEF     = 6'h23;
  localparam logic [5:0] IDX_RT_COEF     = 6'h24;
  localparam logic [5:0] IDX_POLE_A      = 6'h25;
  localparam logic [5:0] IDX_POLE_B      = 6'h26;
  localparam logic [5:0] IDX_POLE_C      = 6'h27;
  localparam logic [5:0] IDX_RING_BIAS   = 6'h28;
  localparam logic [5:0] IDX_OVERHEAD    = 6'h29;
  localparam logic [5:0] IDX_RESERVED    = 6'h2a;
  localparam logic [5:0] IDX_LC_LOW      = 6'h2b;
  localparam logic [5:0] IDX_PROG_STATUS = 6'h2c;
  localparam logic [5:0] IDX_DET_STATUS  = 6'h2d;
  localparam logic [5:0] IDX_FIRST       = 6'h1c;
  localparam logic [5:0] IDX_LAST        = 6'h2b;

  // field positions and limits
  localparam int unsigned BIAS_W      = 4;
  localparam int unsigned OVH_W       = 4;
  localparam logic [3:0]  OVH_MAX_STD = 4'h6;
  localparam logic [3:0]  OVH_MAX_EXT = 4'h9;

  // reset values
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // bus encodings
  localparam logic [2:0]  HSIZE_WORD  = 3'b010;
  localparam logic        HRESP_OKAY  = 1'b0;

endpackage

//--- lic_lowpass.sv
// Purpose: first-order low-pass, y += (x - y) * coef / 2^COEF_W
// Assumes: coef below 2^COEF_W, so y always stays between y and x
// Notes:   updates only on sample_en
`timescale 1ns/1ps
module lic_lowpass
  import lic_pkg::*;
#(
  parameter int unsigned W  = 16,
  parameter int unsigned CW = 13
)(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                sample_en,
  input  wire logic signed [W-1:0] x,
  input  wire logic [CW-1:0]       coef,
  output logic signed [W-1:0]      y
);

  logic signed [W:0]      diff;
  logic signed [W+CW+1:0] prod;
  logic signed [W:0]      next_y;

  // scaled step towards the new sample
  always_comb begin
    diff   = x - y;
    prod   = diff * $signed({1'b0, coef});
    next_y = y + $signed(prod[W+CW:CW]);
  end

  // filter state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      y <= '0;
    end else if (sample_en) begin
      y <= next_y[W-1:0];
    end
  end

endmodule

//--- lic_ahb_slave.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers, one slave on the bus
// Notes:   read data captured at the address phase edge
`timescale 1ns/1ps
module lic_ahb_slave
  import lic_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic [IDX_W-1:0]       rd_idx,
  input  wire logic [DATA_W-1:0] rd_value,
  output logic                   wr_en,
  output logic [IDX_W-1:0]       wr_idx,
  output logic [DATA_W-1:0]      wr_data
);

  logic take;
  logic addr_ok;
  logic dp_write;

  // address phase qualification
  assign take    = hsel && hready && htrans[1];
  assign addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00) && (hsize == HSIZE_WORD);
  assign rd_idx  = haddr[7:2];

  // always ready, always okay
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // write commits in the data phase
  assign wr_en   = dp_write;
  assign wr_data = hwdata[DATA_W-1:0];

  // data phase write tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      wr_idx   <= '0;
    end else begin
      dp_write <= take && hwrite && addr_ok;
      if (take) begin
        wr_idx <= rd_idx;
      end
    end
  end

  // read data, zero for bad or unmapped addresses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RDATA_RESET;
    end else if (take && !hwrite) begin
      hrdata <= addr_ok ? {16'h0, rd_value} : RDATA_RESET;
    end
  end

endmodule

//--- lic_param_bank.sv
// Purpose: line interface parameter bank and the detectors it steers
// Assumes: samples and direct-register bits come from logic on hclk
// Notes:   a detector stays idle until its parameters are written
// Function
// R1 - parameters undefined after reset, never trusted
// R2 - unused bits stored, readable, software writes zero
// R3 - every parameter read as two's complement; coefficients, ringing bias and overhead code are read unsigned here
// R4 - hysteresis on: primary threshold is upper bound
// R5 - loop threshold code step 1.27 mA
// R6 - ring-trip threshold used while ringing
// R7 - below negative common-mode threshold widens bandwidth
// R8 - above positive common-mode threshold widens bandwidth
// R9 - common-mode code step 0.375 V
// R10 - three power-alarm thresholds, one per pair
// R11 - loop-closure and ring-trip filter coefficients
// R12 - thermal poles feed power-alarm estimation
// R13 - software should program ringing bias zero
// R14 - overhead code 0 to 6h, narrow range
// R15 - overhead code 0 to 9h, wide range
// R16 - lower bound closes hysteresis window
// R17 - hysteresis off: lower bound ignored
`timescale 1ns/1ps
module lic_param_bank
  import lic_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // ahb-lite register port
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  // direct-register bits and line state
  input  wire logic                     hysteresis_enable,
  input  wire logic                     ringing_active,
  input  wire logic                     overhead_range_select,
  // measurement samples
  input  wire logic                     sample_en,
  input  wire logic signed [DATA_W-1:0] loop_current,
  input  wire logic signed [DATA_W-1:0] ring_current,
  input  wire logic signed [DATA_W-1:0] common_mode_voltage,
  input  wire logic signed [DATA_W-1:0] power_pair_a,
  input  wire logic signed [DATA_W-1:0] power_pair_b,
  input  wire logic signed [DATA_W-1:0] power_pair_c,
  // results
  output logic                          loop_closed,
  output logic                          ring_trip,
  output logic                          cm_speedup,
  output logic [NUM_PAIR-1:0]           power_alarm,
  output logic [BIAS_W-1:0]             ringing_bias,
  output logic [OVH_W-1:0]              overhead_voltage,
  output logic                          overhead_range_error
);

  // parameter storage and written flags
  logic [DATA_W-1:0]    param_reg [NUM_PARAM];
  logic [NUM_PARAM-1:0] programmed;

  // bus side signals
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_value;
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_data;

  // filtered measurements
  logic signed [DATA_W-1:0] loop_filt;
  logic signed [DATA_W-1:0] ring_filt;
  logic signed [DATA_W-1:0] power_in   [NUM_PAIR];
  logic signed [DATA_W-1:0] power_filt [NUM_PAIR];

  // parameters viewed as signed thresholds and unsigned coefficients and codes
  logic signed [DATA_W-1:0] lc_high;
  logic signed [DATA_W-1:0] lc_low;
  logic signed [DATA_W-1:0] rt_level;
  logic signed [DATA_W-1:0] cm_min;
  logic signed [DATA_W-1:0] cm_max;
  logic signed [DATA_W-1:0] pwr_level  [NUM_PAIR];
  logic [COEF_W-1:0]        pole_coef  [NUM_PAIR];
  logic [COEF_W-1:0]        lc_coef;
  logic [COEF_W-1:0]        rt_coef;
  logic [OVH_W-1:0]         ovh_code;

  // readiness of each detector
  logic lc_ready;
  logic rt_ready;
  logic cm_ready;
  logic [NUM_PAIR-1:0] pwr_ready;

  // detector next values
  logic next_loop_closed;
  logic next_cm_speedup;
  logic ovh_limit_bad;

  // slot number of an index inside the bank
  function automatic logic [3:0] slot_of(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] off;
    off = idx - IDX_FIRST;
    return off[3:0];
  endfunction

  // true for an index that software may write
  function automatic logic is_writable(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_FIRST) && (idx <= IDX_LAST) && (idx != IDX_RESERVED);
  endfunction

  // stored word of a parameter, zero before first write
  function automatic logic [DATA_W-1:0] word_of(input logic [IDX_W-1:0] idx);
    logic [3:0] s;
    s = slot_of(idx);
    return programmed[s] ? param_reg[s] : PARAM_RESET;
  endfunction

  // bus front end
  lic_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_idx    (rd_idx),
    .rd_value  (rd_value),
    .wr_en     (wr_en),
    .wr_idx    (wr_idx),
    .wr_data   (wr_data)
  );

  // R2 unused bits kept
  // whole 16-bit word stored, including bits outside the field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_PARAM; i++) begin
        param_reg[i] <= PARAM_RESET;
      end
    end else if (wr_en && is_writable(wr_idx)) begin
      param_reg[slot_of(wr_idx)] <= wr_data;
    end
  end

  // R1 nothing trusted after reset
  // a flag per parameter, set by its first write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      programmed <= '0;
    end else if (wr_en && is_writable(wr_idx)) begin
      programmed[slot_of(wr_idx)] <= 1'b1;
    end
  end

  // read mux; a write in flight to the same word is forwarded
  always_comb begin
    rd_value = '0;
    if (wr_en && is_writable(wr_idx) && (wr_idx == rd_idx)) begin
      rd_value = wr_data;
    end else if (is_writable(rd_idx)) begin
      rd_value = word_of(rd_idx);
    end else if (rd_idx == IDX_PROG_STATUS) begin
      rd_value = programmed;
    end else if (rd_idx == IDX_DET_STATUS) begin
      rd_value = {7'h0, overhead_range_error, power_alarm, cm_speedup,
                  ring_trip, loop_closed, hysteresis_enable, ringing_active};
    end
  end

  // R3 signed view
  // R5 loop code units
  // R9 common-mode code units
  // samples arrive in the same code units as the thresholds
  always_comb begin // a process, so writes to the storage are seen
    lc_high  = $signed(word_of(IDX_LC_HIGH));
    lc_low   = $signed(word_of(IDX_LC_LOW));
    rt_level = $signed(word_of(IDX_RING_TRIP));
    cm_min   = $signed(word_of(IDX_CM_MIN));
    cm_max   = $signed(word_of(IDX_CM_MAX));
    lc_coef  = COEF_W'(word_of(IDX_LC_COEF));
    rt_coef  = COEF_W'(word_of(IDX_RT_COEF));
    ovh_code = OVH_W'(word_of(IDX_OVERHEAD));
  end

  // R10 one threshold per pair
  // R12 pole per pair
  // per-pair parameters gathered for the generate loop
  always_comb begin
    pwr_level[0] = $signed(word_of(IDX_PWR_A));
    pwr_level[1] = $signed(word_of(IDX_PWR_B));
    pwr_level[2] = $signed(word_of(IDX_PWR_C));
    pole_coef[0] = COEF_W'(word_of(IDX_POLE_A));
    pole_coef[1] = COEF_W'(word_of(IDX_POLE_B));
    pole_coef[2] = COEF_W'(word_of(IDX_POLE_C));
  end
  assign power_in[0]  = power_pair_a;
  assign power_in[1]  = power_pair_b;
  assign power_in[2]  = power_pair_c;

  // R1 detectors wait
  // each detector runs only once its parameters are written
  assign lc_ready = programmed[slot_of(IDX_LC_HIGH)] &&
                    programmed[slot_of(IDX_LC_COEF)] &&
                    (!hysteresis_enable || programmed[slot_of(IDX_LC_LOW)]);
  assign rt_ready = programmed[slot_of(IDX_RING_TRIP)] &&
                    programmed[slot_of(IDX_RT_COEF)];
  assign cm_ready = programmed[slot_of(IDX_CM_MIN)] &&
                    programmed[slot_of(IDX_CM_MAX)];
  assign pwr_ready[0] = programmed[slot_of(IDX_PWR_A)] && programmed[slot_of(IDX_POLE_A)];
  assign pwr_ready[1] = programmed[slot_of(IDX_PWR_B)] && programmed[slot_of(IDX_POLE_B)];
  assign pwr_ready[2] = programmed[slot_of(IDX_PWR_C)] && programmed[slot_of(IDX_POLE_C)];

  // R11 loop filter
  // loop current smoothed before the threshold test
  lic_lowpass #(
    .W  (DATA_W),
    .CW (COEF_W)
  ) u_loop_filt (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sample_en (sample_en),
    .x         (loop_current),
    .coef      (lc_coef),
    .y         (loop_filt)
  );

  // R11 ring-trip filter
  // ring current smoothed before the trip test
  lic_lowpass #(
    .W  (DATA_W),
    .CW (COEF_W)
  ) u_ring_filt (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sample_en (sample_en),
    .x         (ring_current),
    .coef      (rt_coef),
    .y         (ring_filt)
  );

  // loop closure decision
  always_comb begin
    next_loop_closed = loop_closed;
    if (!lc_ready) begin
      next_loop_closed = 1'b0;
    end else if (hysteresis_enable) begin
      // R4 upper bound sets
      if (loop_filt > lc_high) begin
        next_loop_closed = 1'b1;
      // R16 lower bound clears
      end else if (loop_filt < lc_low) begin
        next_loop_closed = 1'b0;
      end
    end else begin
      // R17 single threshold only
      next_loop_closed = (loop_filt > lc_high);
    end
  end

  // loop closure state, moves on a sample, cleared at once while not ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_closed <= 1'b0;
    end else if (sample_en || !lc_ready) begin
      loop_closed <= next_loop_closed;
    end
  end

  // R6 trip while ringing
  // ring trip only meaningful while ringing is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_trip <= 1'b0;
    end else if (!rt_ready || !ringing_active) begin
      ring_trip <= 1'b0;
    end else if (sample_en) begin
      ring_trip <= (ring_filt > rt_level);
    end
  end

  // R7 negative side
  // R8 positive side
  // either excursion selects the wide control bandwidth
  always_comb begin
    next_cm_speedup = 1'b0;
    if (cm_ready) begin
      next_cm_speedup = (common_mode_voltage < -cm_min) ||
                        (common_mode_voltage > cm_max);
    end
  end

  // speed-up request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cm_speedup <= 1'b0;
    end else if (sample_en || !cm_ready) begin
      cm_speedup <= next_cm_speedup;
    end
  end

  // R12 thermal estimate
  // R10 alarm per pair
  // one thermal filter and alarm for each transistor pair
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    lic_lowpass #(
      .W  (DATA_W),
      .CW (COEF_W)
    ) u_thermal (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .sample_en (sample_en),
      .x         (power_in[p]),
      .coef      (pole_coef[p]),
      .y         (power_filt[p])
    );

    // alarm when estimated power passes its threshold
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        power_alarm[p] <= 1'b0;
      end else if (!pwr_ready[p]) begin
        power_alarm[p] <= 1'b0;
      end else if (sample_en) begin
        power_alarm[p] <= (power_filt[p] > pwr_level[p]);
      end
    end
  end

  // R13 bias passed as written
  // bias adjust handed to the ringing path, zero until written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ringing_bias <= '0;
    end else begin
      ringing_bias <= BIAS_W'(word_of(IDX_RING_BIAS));
    end
  end

  // R14 narrow limit
  // R15 wide limit
  // code beyond the allowed range for the selected span
  assign ovh_limit_bad = overhead_range_select ?
                         (ovh_code > OVH_MAX_EXT) :
                         (ovh_code > OVH_MAX_STD);

  // overhead code to the converter, flag when out of range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overhead_voltage     <= '0;
      overhead_range_error <= 1'b0;
    end else begin
      overhead_voltage     <= ovh_code;
      overhead_range_error <= programmed[slot_of(IDX_OVERHEAD)] && ovh_limit_bad;
    end
  end

endmodule

//--- lic_param_bank_sva.sv
// Purpose: port checks for the parameter bank
// Assumes: bound to lic_param_bank, one clock
// Notes:   write data phases tracked in helper flops
`timescale 1ns/1ps
module lic_param_bank_sva
  import lic_pkg::*;
(
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [31:0]         hrdata,
  input wire logic                ringing_active,
  input wire logic                loop_closed,
  input wire logic                ring_trip,
  input wire logic                cm_speedup,
  input wire logic [NUM_PAIR-1:0] power_alarm,
  input wire logic [BIAS_W-1:0]   ringing_bias,
  input wire logic [OVH_W-1:0]    overhead_voltage,
  input wire logic                overhead_range_error
);
  logic        dp_wr;
  logic [31:0] dp_addr;
  logic [31:0] wd_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // word write data phase tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 32'h0000_0000;
      wd_q    <= 32'h0000_0000;
    end else begin
      dp_wr   <= hsel && hready && htrans[1] && hwrite && (hsize == HSIZE_WORD);
      dp_addr <= haddr;
      if (dp_wr) begin
        wd_q <= hwdata;
      end
    end
  end

  property p_ready;
    hreadyout && (hresp == HRESP_OKAY);
  endproperty
  a_ready: assert property (p_ready) else $error("wait state or error response");

  property p_upper;
    hrdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper half not zero");

  property p_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");

  property p_rst;
    $rose(hresetn) |-> !loop_closed && !ring_trip && !cm_speedup && (power_alarm == 3'h0);
  endproperty
  a_rst: assert property (p_rst) else $error("detector active after reset");

  property p_bias;
    dp_wr && (dp_addr == 32'h0000_00a0) |-> ##2 ringing_bias == wd_q[3:0];
  endproperty
  a_bias: assert property (p_bias) else $error("ringing bias not updated");

  property p_ovh;
    dp_wr && (dp_addr == 32'h0000_00a4) |-> ##2 overhead_voltage == wd_q[3:0];
  endproperty
  a_ovh: assert property (p_ovh) else $error("overhead code not updated");

  property p_err_hi;
    (overhead_voltage > 4'h9) [*3] |-> overhead_range_error;
  endproperty
  a_err_hi: assert property (p_err_hi) else $error("overhead code beyond range unflagged");

  property p_err_lo;
    (overhead_voltage <= 4'h6) [*3] |-> !overhead_range_error;
  endproperty
  a_err_lo: assert property (p_err_lo) else $error("legal overhead code flagged");

  property p_ring;
    (!ringing_active) [*2] |-> !ring_trip;
  endproperty
  a_ring: assert property (p_ring) else $error("ring trip outside ringing");
endmodule

bind lic_param_bank lic_param_bank_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ringing_active(ringing_active), .loop_closed(loop_closed), .ring_trip(ring_trip),
  .cm_speedup(cm_speedup), .power_alarm(power_alarm), .ringing_bias(ringing_bias),
  .overhead_voltage(overhead_voltage), .overhead_range_error(overhead_range_error)
);

//--- lic_param_bank_tb.sv
// Purpose: self-checking bench for the parameter bank
// Assumes: zero-wait slave, word transfers only
// Notes:   filters run with the largest coefficient so they settle fast
`timescale 1ns/1ps
module lic_param_bank_tb
  import lic_pkg::*;
;
  logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic               hysteresis_enable, ringing_active, overhead_range_select, sample_en;
  logic               loop_closed, ring_trip, cm_speedup, overhead_range_error;
  logic [1:0]         htrans;
  logic [2:0]         hsize, power_alarm;
  logic [3:0]         ringing_bias, overhead_voltage;
  logic [31:0]        haddr, hwdata, hrdata;
  logic signed [15:0] loop_current, ring_current, common_mode_voltage;
  logic signed [15:0] power_pair_a, power_pair_b, power_pair_c;
  int                 mismatches = 0;
  int                 check_count = 0;
  int                 cycles = 0;

  assign hready = hreadyout;

  lic_param_bank DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hysteresis_enable(hysteresis_enable), .ringing_active(ringing_active),
    .overhead_range_select(overhead_range_select), .sample_en(sample_en),
    .loop_current(loop_current), .ring_current(ring_current),
    .common_mode_voltage(common_mode_voltage), .power_pair_a(power_pair_a),
    .power_pair_b(power_pair_b), .power_pair_c(power_pair_c),
    .loop_closed(loop_closed), .ring_trip(ring_trip), .cm_speedup(cm_speedup),
    .power_alarm(power_alarm), .ringing_bias(ringing_bias),
    .overhead_voltage(overhead_voltage), .overhead_range_error(overhead_range_error)
  );

  // 50 mhz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task automatic samples(input int n);
    repeat (n) begin
      @(posedge hclk);
      sample_en <= 1'b1;
    end
    @(posedge hclk);
    sample_en <= 1'b0;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask

  // same sample on every input, then compare all detector outputs
  task automatic step(input logic signed [15:0] x, input logic [1:0] mode,
                      input logic [5:0] e);
    @(posedge hclk);
    {hysteresis_enable, ringing_active} <= mode;
    loop_current <= x;
    ring_current <= x;
    common_mode_voltage <= x;
    power_pair_a <= x;
    power_pair_b <= x;
    power_pair_c <= x;
    samples(8);
    chk({26'h0, loop_closed, ring_trip, cm_speedup, power_alarm}, {26'h0, e});
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0000_0000;
    hysteresis_enable = 1'b0;
    ringing_active = 1'b0;
    overhead_range_select = 1'b0;
    sample_en = 1'b0;
    {loop_current, ring_current, common_mode_voltage} = 48'h0;
    {power_pair_a, power_pair_b, power_pair_c} = 48'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 32'h1c; i <= 32'h2d; i++) rdc(32'(i * 4), 32'h0000_0000);
    step(16'sh015e, 2'b11, 6'b000000);
    // each word keeps sixteen bits, upper half and reserved dropped
    for (int i = 32'h1c; i <= 32'h2b; i++) begin
      wr(32'(i * 4), {16'h5a5a, 10'h30e, 6'(i)});
      rdc(32'(i * 4), (i == 32'h2a) ? 32'h0 : {16'h0, 10'h30e, 6'(i)});
    end
    wr(32'h0000_0072, 32'h0000_ffff);
    wr(32'h0000_0170, 32'h0000_ffff);
    wr(32'h0000_00fc, 32'h0000_ffff);
    rdc(32'h0000_0070, 32'h0000_c39c);
    rdc(32'h0000_00fc, 32'h0000_0000);
    // real thresholds and coefficients
    wr(32'h0000_0070, 32'h0000_001e);
    wr(32'h0000_00ac, 32'h0000_000a);
    wr(32'h0000_0074, 32'h0000_0032);
    wr(32'h0000_0078, 32'h0000_000a);
    wr(32'h0000_007c, 32'h0000_0014);
    wr(32'h0000_0080, 32'h0000_0064);
    wr(32'h0000_0084, 32'h0000_00c8);
    wr(32'h0000_0088, 32'h0000_012c);
    for (int i = 32'h23; i <= 32'h27; i++) wr(32'(i * 4), 32'h0000_1fff);
    rdc(32'h0000_00b0, 32'h0000_bfff);
    step(16'sh0028, 2'b11, 6'b101000);
    step(16'sh0014, 2'b11, 6'b100000);
    step(16'sh0005, 2'b11, 6'b000000);
    step(16'sh0014, 2'b11, 6'b000000);
    step(16'shfff5, 2'b11, 6'b001000);
    step(16'shfff6, 2'b11, 6'b000000);
    step(16'sh0015, 2'b11, 6'b001000);
    step(16'sh003c, 2'b11, 6'b111000);
    step(16'sh0096, 2'b11, 6'b111001);
    step(16'sh00fa, 2'b11, 6'b111011);
    step(16'sh015e, 2'b11, 6'b111111);
    rdc(32'h0000_00b4, 32'h0000_01ff);
    step(16'sh015e, 2'b10, 6'b101111);
    step(16'sh0014, 2'b00, 6'b000000);
    // bias pass-through and overhead range flag
    wr(32'h0000_00a0, 32'h0000_0000);
    repeat (2) @(negedge hclk);
    chk({28'h0, ringing_bias}, 32'h0000_0000);
    for (int c = 0; c < 32; c++) begin
      @(posedge hclk);
      overhead_range_select <= c[0];
      wr(32'h0000_00a4, 32'(c >> 1));
      repeat (2) @(negedge hclk);
      chk({27'h0, overhead_range_error, overhead_voltage},
          {27'h0, 1'((c >> 1) > (c[0] ? 32'h9 : 32'h6)), 4'(c >> 1)});
    end
    conclude();
  end
endmodule
